/* File: rtl/cop_pkg.sv */
// cop_pkg: shared constants and types for the node protocol ends
// assumes: 20 MHz system clock, frames exchanged as 11-bit id + 8 bytes
package cop_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned MAX_MODULES = 128;
	localparam logic [6:0] NODE_MIN = 7'h01;
	localparam logic [6:0] NODE_MAX = 7'h7f;
	localparam int unsigned ID_W = 11;
	localparam int unsigned DLC_MAX = 8;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned FRAME_W = 11 + 1 + 4 + 64;
	// bit rates in kbit/s
	localparam int unsigned RATE_MIN_KBPS = 20;
	localparam int unsigned RATE_LOW_KBPS = 10;
	localparam int unsigned RATE_HIGH_KBPS = 1000;
	localparam logic [2:0] RATE_SEL_10K = 3'h0;
	localparam logic [2:0] RATE_SEL_20K = 3'h1;
	localparam logic [2:0] RATE_SEL_1M = 3'h7;
	// init phase duration
	localparam int unsigned INIT_TIME_US = 10;
	localparam int unsigned INIT_CYC = (INIT_TIME_US * (CLK_HZ / 1000000));
	// identifier bases
	localparam logic [10:0] ID_NMT = 11'h000;
	localparam logic [10:0] ID_SYNC = 11'h080;
	localparam logic [10:0] ID_EMCY = 11'h080;
	localparam logic [10:0] ID_TPDO1 = 11'h180;
	localparam logic [10:0] ID_RPDO1 = 11'h200;
	localparam logic [10:0] ID_TSDO = 11'h580;
	localparam logic [10:0] ID_RSDO = 11'h600;
	localparam logic [10:0] ID_BOOT = 11'h700;
	// nmt command specifiers
	localparam logic [7:0] NMT_START = 8'h01;
	localparam logic [7:0] NMT_STOP = 8'h02;
	localparam logic [7:0] NMT_PREOP = 8'h80;
	localparam logic [7:0] NMT_RESET = 8'h81;
	// sdo command byte: bit0 last segment flag
	localparam logic [7:0] SDO_CMD_WR = 8'h20;
	localparam logic [7:0] SDO_CMD_RD = 8'h40;
	localparam logic [7:0] SDO_CMD_SEG = 8'h00;
	localparam logic [7:0] SDO_CMD_ACK = 8'h60;
	localparam logic [7:0] SDO_CMD_ABORT = 8'h80;
	localparam logic [7:0] SDO_CMD_DATA = 8'h43;
	localparam logic [7:0] PREOP_BOOT_DATA = 8'h00;

	typedef enum logic [1:0] {
		COP_ST_INIT = 2'b00,
		COP_ST_PREOP = 2'b01,
		COP_ST_OPER = 2'b10,
		COP_ST_PREP = 2'b11
	} cop_nmt_t;

	typedef struct packed {
		logic [10:0] id;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
	} cop_frame_t;
endpackage

/* File: rtl/cop_link_if.sv */
// cop_link_if: frame channels between node and master side
// assumes: one clock, valid/ready handshake per frame
`timescale 1ns/1ps
interface cop_link_if;
	cop_pkg::cop_frame_t m2n_frame;
	logic m2n_valid;
	logic m2n_ready;
	cop_pkg::cop_frame_t n2m_frame;
	logic n2m_valid;
	logic n2m_ready;
	modport node (input m2n_frame, input m2n_valid, output m2n_ready,
		output n2m_frame, output n2m_valid, input n2m_ready);
	modport master (output m2n_frame, output m2n_valid, input m2n_ready,
		input n2m_frame, input n2m_valid, output n2m_ready);
endinterface

/* File: rtl/cop_fifo.sv */
// cop_fifo: small valid/ready FIFO for outgoing frames
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/1ps
module cop_fifo #(
	parameter int unsigned WIDTH = 80,
	parameter int unsigned DEPTH = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic [WIDTH-1:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	output logic [WIDTH-1:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;
	assign o_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign o_valid = (cnt_ff != '0);
	assign o_data = mem_ff[rd_ff];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem_ff[wr_ff] <= i_data;
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
			end
			if (push && !pop) begin
				cnt_ff <= cnt_ff + (AW+1)'(1);
			end else if (pop && !push) begin
				cnt_ff <= cnt_ff - (AW+1)'(1);
			end
		end
	end
endmodule

/* File: rtl/cop_node.sv */
// cop_node: network node end, nmt states, sdo server, pdo producer
// assumes: frames arrive from the link one per handshake, one clock
// Functional notes
// RQ1: at most 128 modules, one master
// RQ2: node address accepted only 1..127
// RQ3: 20 kbit/s mandatory, 10k..1M optional
// RQ4: sdo confirmed, one request one response object
// RQ5: sdo addresses index plus sub-index
// RQ6: long sdo data split into segments
// RQ7: pdo unconfirmed, at most 8 bytes
// RQ8: pdo sent on internal event
// RQ9: remote request answered with pdo
// RQ10: pdo sent on each sync
// RQ11: rx pdo adopted at sync
// RQ12: power-up enters initialization
// RQ13: boot-up frame sent during initialization
// RQ14: init completes into pre-operational automatically
// RQ15: pre-op: sdo only, no pdo, no emergency
// RQ16: prepared: no sdo, no pdo
// RQ17: prepared left only by nmt command
// RQ18: operational: free to transmit
// RQ19: exactly one master, rest slaves
// RQ20: master commands slave state changes
// RQ21: all identifiers 11-bit standard
// RQ22: emergency on device error outside restricted states
// RQ23: start command enters operational
`timescale 1ns/1ps
module cop_node (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	cop_link_if.node link,
	input wire logic [6:0] i_node_id,
	input wire logic [2:0] i_rate_sel,
	input wire logic i_event,
	input wire logic [63:0] i_tx_pdo,
	input wire logic i_dev_err,
	input wire logic [15:0] i_err_code,
	output logic [1:0] o_nmt_state,
	output logic [63:0] o_rx_pdo,
	output logic o_addr_ok,
	output logic [2:0] o_rate,
	output logic [15:0] o_sdo_index,
	output logic [7:0] o_sdo_sub,
	output logic [31:0] o_sdo_wdata,
	output logic o_sdo_wr
);
	cop_pkg::cop_nmt_t st_ff;
	logic [6:0] id_ff;
	logic [15:0] init_cnt_ff;
	logic boot_done_ff;
	logic [63:0] rx_stage_ff;
	logic [31:0] seg_data_ff;
	logic [15:0] idx_ff;
	logic [7:0] sub_ff;
	logic err_d_ff;
	cop_pkg::cop_frame_t q_frame;
	cop_pkg::cop_frame_t in_f;
	logic q_valid;
	logic q_ready;
	logic take;
	logic is_nmt;
	logic is_sync;
	logic is_rsdo;
	logic is_rpdo;
	logic is_rtr;
	logic nmt_mine;
	logic talk;
	logic pdo_ok;
	logic emcy_ok;
	logic sdo_ok;
	logic emcy_go;

	assign in_f = link.m2n_frame;
	assign take = link.m2n_valid && link.m2n_ready;
	assign nmt_mine = in_f.data[15:8] == {1'b0, id_ff} || in_f.data[15:8] == 8'h00;
	assign is_nmt = in_f.id == cop_pkg::ID_NMT && nmt_mine;
	assign is_sync = in_f.id == cop_pkg::ID_SYNC;
	assign is_rsdo = in_f.id == (cop_pkg::ID_RSDO | {4'h0, id_ff}); // [RQ2]
	assign is_rpdo = in_f.id == (cop_pkg::ID_RPDO1 | {4'h0, id_ff}) && !in_f.rtr;
	assign is_rtr = in_f.id == (cop_pkg::ID_TPDO1 | {4'h0, id_ff}) && in_f.rtr;
	assign sdo_ok = o_addr_ok && (st_ff == cop_pkg::COP_ST_PREOP
		|| st_ff == cop_pkg::COP_ST_OPER); // [RQ15] [RQ16]
	assign pdo_ok = o_addr_ok && st_ff == cop_pkg::COP_ST_OPER; // [RQ15] [RQ18]
	assign emcy_ok = pdo_ok; // [RQ22]
	// hold input while the tx queue is full so no answer is lost
	assign link.m2n_ready = q_ready;

	// address latched after reset release; 0 marks invalid
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			id_ff <= 7'h00;
			o_addr_ok <= 1'b0;
			o_rate <= cop_pkg::RATE_SEL_20K;
		end else if (st_ff == cop_pkg::COP_ST_INIT) begin
			id_ff <= i_node_id;
			o_addr_ok <= i_node_id >= cop_pkg::NODE_MIN
				&& i_node_id <= cop_pkg::NODE_MAX; // [RQ2] [RQ1]
			o_rate <= (i_rate_sel > cop_pkg::RATE_SEL_1M) ?
				cop_pkg::RATE_SEL_20K : i_rate_sel; // [RQ3]
		end
	end

	// network management state
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_ff <= cop_pkg::COP_ST_INIT; // [RQ12]
			init_cnt_ff <= '0;
		end else begin
			case (st_ff)
				cop_pkg::COP_ST_INIT: begin
					if (init_cnt_ff == 16'(cop_pkg::INIT_CYC - 1)) begin
						if (boot_done_ff || !o_addr_ok) begin
							st_ff <= cop_pkg::COP_ST_PREOP; // [RQ14]
							init_cnt_ff <= '0;
						end
					end else begin
						init_cnt_ff <= init_cnt_ff + 16'h0001;
					end
				end
				default: begin
					if (take && is_nmt) begin // [RQ17] [RQ20]
						case (in_f.data[7:0])
							cop_pkg::NMT_START: st_ff <= cop_pkg::COP_ST_OPER; // [RQ23]
							cop_pkg::NMT_STOP: st_ff <= cop_pkg::COP_ST_PREP;
							cop_pkg::NMT_PREOP: st_ff <= cop_pkg::COP_ST_PREOP;
							cop_pkg::NMT_RESET: st_ff <= cop_pkg::COP_ST_INIT;
							default: st_ff <= st_ff;
						endcase
					end
				end
			endcase
		end
	end
	assign o_nmt_state = st_ff;

	// sdo request capture
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			idx_ff <= '0;
			sub_ff <= '0;
			seg_data_ff <= '0;
			o_sdo_wr <= 1'b0;
		end else begin
			o_sdo_wr <= 1'b0;
			if (take && is_rsdo && sdo_ok) begin
				if (in_f.data[7:5] != 3'b000) begin
					idx_ff <= in_f.data[23:8]; // [RQ5]
					sub_ff <= in_f.data[31:24];
					seg_data_ff <= in_f.data[63:32];
					o_sdo_wr <= in_f.data[7:0] == cop_pkg::SDO_CMD_WR;
				end else begin
					seg_data_ff <= in_f.data[39:8]; // [RQ6]
					o_sdo_wr <= 1'b1;
				end
			end
		end
	end
	assign o_sdo_index = idx_ff;
	assign o_sdo_sub = sub_ff;
	assign o_sdo_wdata = seg_data_ff;

	// received pdo staged then adopted on sync
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_stage_ff <= '0;
			o_rx_pdo <= '0;
		end else begin
			if (take && is_rpdo && pdo_ok) begin
				rx_stage_ff <= in_f.data;
			end
			if (take && is_sync && pdo_ok) begin
				o_rx_pdo <= rx_stage_ff; // [RQ11]
			end
		end
	end

	// transmit request selection into the queue
	always_comb begin
		q_valid = 1'b0;
		q_frame = '0;
		emcy_go = 1'b0;
		if (st_ff == cop_pkg::COP_ST_INIT && !boot_done_ff && o_addr_ok) begin
			q_valid = 1'b1; // [RQ13]
			q_frame.id = cop_pkg::ID_BOOT | {4'h0, id_ff}; // [RQ21]
			q_frame.dlc = 4'h1;
			q_frame.data[7:0] = cop_pkg::PREOP_BOOT_DATA;
		end else if (take && is_rsdo && sdo_ok) begin
			q_valid = 1'b1; // [RQ4]
			q_frame.id = cop_pkg::ID_TSDO | {4'h0, id_ff};
			q_frame.dlc = 4'h8;
			q_frame.data[7:0] = (in_f.data[7:0] == cop_pkg::SDO_CMD_RD) ?
				cop_pkg::SDO_CMD_DATA : cop_pkg::SDO_CMD_ACK;
			q_frame.data[31:8] = in_f.data[31:8];
		end else if (pdo_ok && ((take && (is_rtr || is_sync)) || i_event)) begin
			q_valid = 1'b1; // [RQ7] [RQ8] [RQ9] [RQ10]
			q_frame.id = cop_pkg::ID_TPDO1 | {4'h0, id_ff};
			q_frame.dlc = 4'(cop_pkg::DLC_MAX);
			q_frame.data = i_tx_pdo;
		end else if (emcy_ok && i_dev_err && !err_d_ff) begin
			q_valid = 1'b1; // [RQ22]
			emcy_go = 1'b1;
			q_frame.id = cop_pkg::ID_EMCY | {4'h0, id_ff};
			q_frame.dlc = 4'h2;
			q_frame.data[15:0] = i_err_code;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			boot_done_ff <= 1'b0;
			err_d_ff <= 1'b0;
		end else begin
			if (st_ff == cop_pkg::COP_ST_INIT && q_valid && q_ready) begin
				boot_done_ff <= 1'b1;
			end else if (st_ff != cop_pkg::COP_ST_INIT) begin
				boot_done_ff <= 1'b0;
			end
			// edge kept pending while a pdo wins the queue slot
			if (!(emcy_ok && i_dev_err && !err_d_ff)
				|| (emcy_go && q_ready)) begin // [RQ22]
				err_d_ff <= i_dev_err;
			end
		end
	end

	cop_fifo #(
		.WIDTH(cop_pkg::FRAME_W),
		.DEPTH(cop_pkg::FIFO_DEPTH)
	) u_txq (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_data(q_frame),
		.i_valid(q_valid),
		.o_ready(q_ready),
		.o_data(link.n2m_frame),
		.o_valid(link.n2m_valid),
		.i_ready(link.n2m_ready)
	);
endmodule

/* File: rtl/cop_master.sv */
// cop_master: network management master end driving one node
// assumes: user issues one command pulse at a time, one clock
`timescale 1ns/1ps
module cop_master (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	cop_link_if.master link,
	input wire logic i_cmd_valid,
	input wire logic [1:0] i_cmd_kind,
	input wire logic [6:0] i_target,
	input wire logic [10:0] i_id,
	input wire logic [63:0] i_data,
	output logic o_cmd_ready,
	output logic o_rx_valid,
	output logic [10:0] o_rx_id,
	output logic [63:0] o_rx_data
);
	// kinds: 0 nmt (i_data[7:0] command), 1 sync, 2 raw frame, 3 rtr
	cop_pkg::cop_frame_t f_ff;
	logic busy_ff;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_ff <= 1'b0;
			f_ff <= '0;
		end else if (!busy_ff && i_cmd_valid) begin
			busy_ff <= 1'b1;
			f_ff <= '0;
			case (i_cmd_kind)
				2'h0: begin
					f_ff.id <= cop_pkg::ID_NMT; // [RQ19] [RQ20]
					f_ff.dlc <= 4'h2;
					f_ff.data[15:0] <= {1'b0, i_target, i_data[7:0]};
				end
				2'h1: f_ff.id <= cop_pkg::ID_SYNC;
				2'h3: begin
					f_ff.id <= i_id; // [RQ9] [RQ21]
					f_ff.rtr <= 1'b1;
				end
				default: begin
					f_ff.id <= i_id; // [RQ4] [RQ5] [RQ6]
					f_ff.dlc <= 4'h8;
					f_ff.data <= i_data;
				end
			endcase
		end else if (busy_ff && link.m2n_ready) begin
			busy_ff <= 1'b0;
		end
	end
	assign link.m2n_valid = busy_ff;
	assign link.m2n_frame = f_ff;
	assign o_cmd_ready = !busy_ff;
	assign link.n2m_ready = 1'b1;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rx_valid <= 1'b0;
			o_rx_id <= '0;
			o_rx_data <= '0;
		end else begin
			o_rx_valid <= link.n2m_valid;
			if (link.n2m_valid) begin
				o_rx_id <= link.n2m_frame.id;
				o_rx_data <= link.n2m_frame.data;
			end
		end
	end
endmodule

/* File: tb/cop_props.sv */
// cop_props: link wire checks between master end and node end
// assumes: signals of one cop_link_if, one clock, async low reset
`timescale 1ns/1ps
module cop_props (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire cop_pkg::cop_frame_t m2n_frame,
	input wire logic m2n_valid,
	input wire logic m2n_ready,
	input wire cop_pkg::cop_frame_t n2m_frame,
	input wire logic n2m_valid,
	input wire logic n2m_ready
);
	logic seen_ff;
	// marks the first node frame after reset
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			seen_ff <= 1'b0;
		end else if (n2m_valid && n2m_ready) begin
			seen_ff <= 1'b1;
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	AST_N2M_HOLD: assert property (n2m_valid && !n2m_ready |=>
		n2m_valid && $stable(n2m_frame)) else $error("node frame dropped");
	AST_M2N_HOLD: assert property (m2n_valid && !m2n_ready |=>
		m2n_valid && $stable(m2n_frame)) else $error("master frame dropped");
	AST_DLC_MAX: assert property (n2m_valid |->
		n2m_frame.dlc <= 4'h8) else $error("node frame too long");
	AST_ID_ADDR: assert property (n2m_valid |->
		n2m_frame.id[6:0] != 7'h00) else $error("node id without address");
	AST_ID_STD: assert property (n2m_valid |-> n2m_frame.id[10:7] inside
		{4'h1, 4'h3, 4'hb, 4'he}) else $error("node id outside its set");
	AST_BOOT_FIRST: assert property (n2m_valid && !seen_ff |->
		n2m_frame.id[10:7] == 4'he && n2m_frame.data[7:0] == 8'h00)
		else $error("first frame is not boot-up");
	AST_NO_RTR: assert property (n2m_valid |->
		!n2m_frame.rtr) else $error("node sent remote request");
	AST_RESET_IDLE: assert property ($rose(i_resetn) |->
		!n2m_valid) else $error("frame right after reset");
	cover property (n2m_valid && n2m_ready && !seen_ff);
	cover property (m2n_valid && m2n_ready && m2n_frame.id[10:7] == 4'hc);
	cover property (m2n_valid && m2n_ready && m2n_frame.rtr);
endmodule

/* File: tb/tb_canopen_node_protocol.sv */
// tb_canopen_node_protocol: master end drives node end over the link
// assumes: rtl files compiled first, 20 MHz clock
`timescale 1ns/1ps
module tb_canopen_node_protocol;
	logic i_sys_clk, i_resetn, cmd_valid, ev, dev_err, cmd_ready;
	logic rx_valid, addr_ok, sdo_wr;
	logic [1:0] kind, state;
	logic [6:0] tgt, nid;
	logic [2:0] rsel, rate;
	logic [10:0] tid, rx_id;
	logic [63:0] dat, rx_data, tx_pdo, rx_pdo;
	logic [15:0] ecode, sdo_index;
	logic [7:0] sdo_sub;
	logic [31:0] sdo_wdata;
	int err_count = 0, total_checks = 0, rx_cnt = 0, wr_cnt = 0, k;
	cop_link_if lk();
	cop_master i_cop_master (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.link(lk), .i_cmd_valid(cmd_valid), .i_cmd_kind(kind),
		.i_target(tgt), .i_id(tid), .i_data(dat), .o_cmd_ready(cmd_ready),
		.o_rx_valid(rx_valid), .o_rx_id(rx_id), .o_rx_data(rx_data));
	cop_node i_cop_node (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.link(lk), .i_node_id(nid), .i_rate_sel(rsel), .i_event(ev),
		.i_tx_pdo(tx_pdo), .i_dev_err(dev_err), .i_err_code(ecode),
		.o_nmt_state(state), .o_rx_pdo(rx_pdo), .o_addr_ok(addr_ok),
		.o_rate(rate), .o_sdo_index(sdo_index), .o_sdo_sub(sdo_sub),
		.o_sdo_wdata(sdo_wdata), .o_sdo_wr(sdo_wr));
	cop_props i_cop_props (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.m2n_frame(lk.m2n_frame), .m2n_valid(lk.m2n_valid),
		.m2n_ready(lk.m2n_ready), .n2m_frame(lk.n2m_frame),
		.n2m_valid(lk.n2m_valid), .n2m_ready(lk.n2m_ready));
	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	// counts received frames and write strobes
	always @(posedge i_sys_clk) begin
		if (rx_valid === 1'b1) rx_cnt++;
		if (sdo_wr === 1'b1) wr_cnt++;
	end
	task automatic give_verdict;
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			err_count++;
			give_verdict();
		end
	endtask
	task automatic send(input logic [1:0] kd, input logic [10:0] id,
		input logic [63:0] d);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		cmd_valid <= 1'b1;
		kind <= kd;
		tid <= id;
		dat <= d;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 400);
		cmd_valid <= 1'b0;
		bound(n, 400);
	endtask
	task automatic nmt(input logic [7:0] c, input logic [6:0] t);
		tgt <= t;
		send(2'h0, 11'h000, {48'h0, 1'b0, t, c});
		tgt <= 7'h05;
	endtask
	task automatic rx(input logic [10:0] id, input logic [63:0] d,
		input bit cd);
		int n;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (rx_valid !== 1'b1 && n < 300);
		bound(n, 300);
		chk({53'h0, rx_id}, {53'h0, id});
		if (cd) chk(rx_data, d);
	endtask
	task automatic wst(input logic [1:0] s);
		int n;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (state !== s && n < 400);
		bound(n, 400);
		chk({62'h0, state}, {62'h0, s});
	endtask
	task automatic quiet(input int c);
		int r;
		r = rx_cnt;
		repeat (c) @(posedge i_sys_clk);
		chk(64'(rx_cnt), 64'(r));
	endtask
	task automatic pulse;
		@(posedge i_sys_clk);
		ev <= 1'b1;
		@(posedge i_sys_clk);
		ev <= 1'b0;
	endtask
	initial begin
		i_resetn = 1'b0;
		cmd_valid = 1'b0;
		kind = 2'h0;
		tid = 11'h000;
		dat = 64'h0;
		tgt = 7'h05;
		ev = 1'b0;
		dev_err = 1'b0;
		nid = 7'h05;
		rsel = 3'h1;
		tx_pdo = 64'h1122334455667788;
		ecode = 16'h2100;
		repeat (2) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		@(posedge i_sys_clk);
		chk({62'h0, state}, 64'h0);
		rx(11'h705, 64'h0, 1'b0);
		wst(2'h1);
		chk({63'h0, addr_ok}, 64'h1);
		chk({61'h0, rate}, {61'h0, cop_pkg::RATE_SEL_20K});
		dev_err <= 1'b1;
		pulse();
		quiet(40);
		dev_err <= 1'b0;
		send(2'h2, 11'h605, {32'hcafe0123, 8'h02, 16'h2000,
			cop_pkg::SDO_CMD_WR});
		rx(11'h585, {32'h0, 8'h02, 16'h2000, cop_pkg::SDO_CMD_ACK},
			1'b1);
		chk({48'h0, sdo_index}, 64'h2000);
		chk({56'h0, sdo_sub}, 64'h02);
		chk({32'h0, sdo_wdata}, 64'hcafe0123);
		chk(64'(wr_cnt), 64'h1);
		send(2'h2, 11'h605, {24'h0, 32'h89abcdef, cop_pkg::SDO_CMD_SEG});
		rx(11'h585, 64'h0, 1'b0);
		chk({32'h0, sdo_wdata}, 64'h89abcdef);
		chk({48'h0, sdo_index}, 64'h2000);
		chk(64'(wr_cnt), 64'h2);
		nmt(cop_pkg::NMT_START, 7'h05);
		wst(2'h2);
		pulse();
		rx(11'h185, tx_pdo, 1'b1);
		send(2'h3, 11'h185, 64'h0);
		rx(11'h185, tx_pdo, 1'b1);
		send(2'h2, 11'h205, 64'h0a0b0c0d01020304);
		quiet(20);
		chk(rx_pdo, 64'h0);
		send(2'h1, 11'h080, 64'h0);
		rx(11'h185, tx_pdo, 1'b1);
		chk(rx_pdo, 64'h0a0b0c0d01020304);
		dev_err <= 1'b1;
		rx(11'h085, {48'h0, ecode}, 1'b1);
		dev_err <= 1'b0;
		nmt(cop_pkg::NMT_STOP, 7'h09);
		quiet(20);
		chk({62'h0, state}, 64'h2);
		nmt(cop_pkg::NMT_STOP, 7'h00);
		wst(2'h3);
		for (k = 0; k < 3; k++) begin
			if (k == 0) send(2'h2, 11'h605, {56'h0, cop_pkg::SDO_CMD_RD});
			if (k == 1) send(2'h1, 11'h080, 64'h0);
			if (k == 2) pulse();
			quiet(40);
		end
		chk(64'(wr_cnt), 64'h2);
		chk({62'h0, state}, 64'h3);
		nmt(cop_pkg::NMT_START, 7'h05);
		wst(2'h2);
		// second reset with an invalid address: node must stay silent
		nid <= 7'h00;
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		quiet(250);
		chk({62'h0, state}, 64'h1);
		chk({63'h0, addr_ok}, 64'h0);
		send(2'h2, 11'h600, {56'h0, cop_pkg::SDO_CMD_RD});
		quiet(40);
		chk(64'(wr_cnt), 64'h2);
		give_verdict();
	end
endmodule
